//--- hdl/sbcmd_decoder.v
// Purpose: decode chip operating mode into per-block output states
// Assumes: mode and bus inputs synchronous to pclk; APB slave with one wait state, registered decode
// Notes: every output but the tied-low fallback_o is registered, so outputs lag inputs by one pclk
`timescale 1ns/10ps
`include "sbcmd_defines.vh"
// Behaviour
// - Secondary regulator off in Off/Overload, on in Forced Normal, else its field.
// - HV I/O follow config; low-side forced off in Standby/Sleep/Reset/FORCED_SLEEP_PREP.
// - HV I/O off in Off and Forced Normal, fail-safe in Overload.
// - SMPS off Off/Overload, default Forced Normal, on Reset/FORCED_SLEEP_PREP, else config.
// - CAN by mode field; Off on shutdown, Off/Overload; active Forced Normal; Reset/FORCED_SLEEP_PREP offline or bias only.
// - LIN off Off/Overload, active Forced Normal, offline Sleep/Reset/FORCED_SLEEP_PREP, else field.
// - Second LIN and HV I/O pins exist only per variant parameters.
// - Enable pin off in Off/Forced Normal/Reset/Overload, else control and drive fields.
// - Enable pin is open-drain in Sleep, or when the drive config bit is set.
// - Fallback floats Off/Forced Normal, active in Overload/FORCED_SLEEP_PREP, else its bit.
// - Watchdog off except Standby, Normal, Sleep where its mode field rules.
// - In Overload fallback bit is set to one and reset output driven low.
module sbcmd_decoder #(
  parameter HAS_LIN2 = 1,
  parameter HAS_HVIO = 1,
  parameter HVIO_N = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Mode and conditions
  input wire [2:0] chip_mode,
  input wire can_shutdown,
  input wire can_wake,
  input wire [1:0] lin_wake,
  input wire can_bus_rx,
  input wire [1:0] lin_bus_rx,
  // Supplies
  output wire secondary_regulator,
  output wire smps_on,
  output wire smps_default_v,
  // High-voltage I/O
  output wire [HVIO_N-1:0] hv_io_hs_en,
  output wire [HVIO_N-1:0] hv_io_ls_en,
  output wire [HVIO_N-1:0] hv_io_failsafe,
  // Transceivers
  output wire [2:0] can_state,
  output wire [1:0] lin1_state,
  output wire [1:0] lin2_state,
  output wire can_receive_out,
  output wire [1:0] lin_receive_out,
  // Pins and functions
  output wire en_pin_o,
  output wire en_pin_oe,
  output wire reset_out_low,
  output wire fallback_o,
  output wire fallback_oe,
  output wire [1:0] spi_state,
  output wire [2:0] wd_mode
);
  // APB side and software registers
  reg [31:0] prdata_ff, nxt_rdata;
  reg pready_ff, pslverr_ff, nxt_err;
  reg [`SBCMD_CTRL_W-1:0] ctrl_ff;
  reg [`SBCMD_FSAFE_W-1:0] fsafe_ff, nxt_fsafe;
  reg [2*HVIO_N-1:0] hvio_ff;
  // Decoded outputs and their next values
  reg v2_ff, smps_ff, smps_def_ff, crx_ff, en_o_ff, en_oe_ff, rst_low_ff, fb_oe_ff;
  reg nxt_v2, nxt_smps, nxt_smps_def, nxt_crx, nxt_en_o, nxt_en_oe, nxt_rst_low, nxt_fb_oe;
  reg [1:0] lin1_ff, lin2_ff, lrx_ff, spi_ff, nxt_spi;
  reg [2:0] can_ff, wd_ff, nxt_can, nxt_wd;
  reg [HVIO_N-1:0] hs_ff, ls_ff, fs_ff, nxt_hs, nxt_ls, nxt_fs;
  wire access, wr_done, hv_present, lin2_present;
  wire [1:0] can_mode_ctrl, nxt_lin1, nxt_lin2, nxt_lrx;
  wire [HVIO_N-1:0] hs_cfg, ls_cfg;
  // Field helpers
  function [1:0] fld2;
    input [`SBCMD_CTRL_W-1:0] r;
    input integer lsb;
    begin
      fld2 = r[lsb +: 2];
    end
  endfunction
  assign access = psel & penable;
  assign wr_done = access & pready_ff & pwrite;
  assign can_mode_ctrl = fld2(ctrl_ff, `SBCMD_CMC_LSB);
  assign hv_present = (HAS_HVIO != 0);
  assign lin2_present = (HAS_LIN2 != 0);

  // Split per-pin high-side and low-side enables
  genvar g;
  generate
    for (g = 0; g < HVIO_N; g = g + 1) begin : g_hv
      assign hs_cfg[g] = hvio_ff[2*g];
      assign ls_cfg[g] = hvio_ff[2*g+1];
    end
  endgenerate

  // LIN channels; second one gated by variant
  sbcmd_lin_dec u_lin1 (
    .mode(chip_mode), .lin_mode_ctrl(fld2(ctrl_ff, `SBCMD_LMC1_LSB)), .present(1'b1),
    .wake(lin_wake[0]), .bus_rx(lin_bus_rx[0]), .state(nxt_lin1), .lin_receive_out(nxt_lrx[0])
  );
  sbcmd_lin_dec u_lin2 (
    .mode(chip_mode), .lin_mode_ctrl(fld2(ctrl_ff, `SBCMD_LMC2_LSB)), .present(lin2_present),
    .wake(lin_wake[1]), .bus_rx(lin_bus_rx[1]), .state(nxt_lin2), .lin_receive_out(nxt_lrx[1])
  );

  // Read mux and unmapped-address error
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    case (paddr)
      `SBCMD_OFS_CTRL: nxt_rdata[`SBCMD_CTRL_W-1:0] = ctrl_ff;
      `SBCMD_OFS_FSAFE: nxt_rdata[`SBCMD_FSAFE_W-1:0] = fsafe_ff;
      `SBCMD_OFS_HVIO: nxt_rdata[2*HVIO_N-1:0] = hvio_ff;
      `SBCMD_OFS_STAT: begin
        nxt_err = pwrite; // Status is read-only
        nxt_rdata[17:0] = {smps_ff, v2_ff, rst_low_ff, wd_ff, spi_ff,
                           lin2_ff, lin1_ff, can_ff, chip_mode};
      end
      default: nxt_err = 1'b1;
    endcase
  end

  // Fail-safe register: hardware set of fallback bit wins over a write
  always @* begin
    nxt_fsafe = fsafe_ff;
    if (wr_done && paddr == `SBCMD_OFS_FSAFE) begin
      nxt_fsafe = pwdata[`SBCMD_FSAFE_W-1:0];
    end
    if (chip_mode == `SBCMD_M_OVL || chip_mode == `SBCMD_M_FSP) begin
      nxt_fsafe[`SBCMD_LHC_BIT] = 1'b1;
    end
  end

  // APB slave: one wait state so every answer comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      ctrl_ff <= `SBCMD_CTRL_RST;
      fsafe_ff <= `SBCMD_FSAFE_RST;
      hvio_ff <= {(2*HVIO_N){1'b0}};
    end else begin
      pready_ff <= access & ~pready_ff;
      if (access && !pready_ff) begin
        prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
        pslverr_ff <= nxt_err;
      end else begin
        pslverr_ff <= 1'b0;
      end
      if (wr_done && paddr == `SBCMD_OFS_CTRL) begin
        ctrl_ff <= pwdata[`SBCMD_CTRL_W-1:0];
      end
      if (wr_done && paddr == `SBCMD_OFS_HVIO) begin
        hvio_ff <= pwdata[2*HVIO_N-1:0];
      end
      fsafe_ff <= nxt_fsafe;
    end
  end

  // Supplies, HV I/O, pins and functions per mode
  always @* begin
    nxt_v2 = (fld2(ctrl_ff, `SBCMD_V2C_LSB) != 2'h0);
    nxt_smps = ctrl_ff[`SBCMD_SMPS_ON];
    nxt_smps_def = ~ctrl_ff[`SBCMD_SMPS_ALT];
    nxt_hs = {HVIO_N{1'b0}};
    nxt_ls = {HVIO_N{1'b0}};
    nxt_fs = {HVIO_N{1'b0}};
    nxt_en_o = 1'b0;
    nxt_en_oe = 1'b0;
    nxt_rst_low = 1'b0; // Low means asserted
    nxt_fb_oe = fsafe_ff[`SBCMD_LHC_BIT];
    nxt_spi = `SBCMD_SPI_DIS;
    nxt_wd = `SBCMD_WD_OFF;
    case (chip_mode)
      `SBCMD_M_OFF: begin
        nxt_v2 = 1'b0;
        nxt_smps = 1'b0;
        nxt_fb_oe = 1'b0;
      end
      `SBCMD_M_FNM: begin
        nxt_v2 = 1'b1;
        nxt_smps = 1'b1;
        nxt_smps_def = 1'b1;
        nxt_rst_low = 1'b1;
        nxt_fb_oe = 1'b0;
        nxt_spi = `SBCMD_SPI_LIM;
      end
      `SBCMD_M_STB, `SBCMD_M_NRM: begin
        nxt_hs = hs_cfg;
        nxt_ls = (chip_mode == `SBCMD_M_NRM) ? ls_cfg : {HVIO_N{1'b0}};
        nxt_rst_low = 1'b1;
        nxt_spi = `SBCMD_SPI_ACT;
        nxt_wd = ctrl_ff[`SBCMD_WMC_LSB +: 3];
      end
      `SBCMD_M_SLP: begin
        nxt_hs = hs_cfg;
        nxt_wd = ctrl_ff[`SBCMD_WMC_LSB +: 3];
      end
      `SBCMD_M_RST: begin
        nxt_hs = hs_cfg;
        nxt_smps = 1'b1;
      end
      `SBCMD_M_OVL: begin
        nxt_v2 = 1'b0;
        nxt_smps = 1'b0;
        nxt_fs = {HVIO_N{1'b1}};
        nxt_fb_oe = 1'b1;
      end
      `SBCMD_M_FSP: begin
        nxt_hs = hs_cfg;
        nxt_smps = 1'b1;
        nxt_fb_oe = 1'b1;
      end
      default: nxt_spi = `SBCMD_SPI_DIS;
    endcase
    // Enable pin: push-pull drives both levels, open-drain only pulls low
    if (chip_mode == `SBCMD_M_STB || chip_mode == `SBCMD_M_NRM ||
        chip_mode == `SBCMD_M_SLP || chip_mode == `SBCMD_M_FSP) begin
      if (fsafe_ff[`SBCMD_EN_PIN_DRIVE_CFG_BIT] || chip_mode == `SBCMD_M_SLP) begin
        nxt_en_o = 1'b0;
        nxt_en_oe = ~fsafe_ff[`SBCMD_ENC_LSB];
      end else begin
        nxt_en_o = fsafe_ff[`SBCMD_ENC_LSB];
        nxt_en_oe = fsafe_ff[`SBCMD_ENC_LSB + 1];
      end
    end
    // Absent HV I/O pins stay inert
    if (!hv_present) begin
      nxt_hs = {HVIO_N{1'b0}};
      nxt_ls = {HVIO_N{1'b0}};
      nxt_fs = {HVIO_N{1'b0}};
    end
  end

  // CAN state and receive line
  always @* begin
    nxt_can = `SBCMD_CAN_OFF;
    nxt_crx = 1'b1;
    case (chip_mode)
      `SBCMD_M_FNM: begin
        nxt_can = `SBCMD_CAN_ACT;
        nxt_crx = can_bus_rx;
      end
      `SBCMD_M_STB, `SBCMD_M_NRM, `SBCMD_M_SLP: begin
        // Active only in Normal; elsewhere the active codes give offline bias
        if (can_mode_ctrl == `SBCMD_MC_LSN) begin
          nxt_can = `SBCMD_CAN_LSN;
        end else if (can_mode_ctrl == `SBCMD_MC_OFFL) begin
          nxt_can = `SBCMD_CAN_OFFL;
        end else begin
          nxt_can = (chip_mode == `SBCMD_M_NRM) ? `SBCMD_CAN_ACT : `SBCMD_CAN_BIAS;
        end
        // Sleep keeps the pull-up; Normal listen shows the bus just as Standby does
        if (chip_mode != `SBCMD_M_SLP) begin
          nxt_crx = (can_mode_ctrl == `SBCMD_MC_LSN || (chip_mode == `SBCMD_M_NRM && can_mode_ctrl != `SBCMD_MC_OFFL))
            ? can_bus_rx : ~can_wake;
        end
      end
      `SBCMD_M_RST, `SBCMD_M_FSP: begin
        nxt_can = (can_mode_ctrl == `SBCMD_MC_OFFL) ? `SBCMD_CAN_OFFL : `SBCMD_CAN_BIAS;
        if (chip_mode == `SBCMD_M_RST) begin
          nxt_crx = ~can_wake;
        end
      end
      default: nxt_can = `SBCMD_CAN_OFF;
    endcase
    if (can_shutdown) begin
      nxt_can = `SBCMD_CAN_OFF;
    end
  end

  // Output registers; reset gives the Off-mode picture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v2_ff <= 1'b0;
      smps_ff <= 1'b0;
      smps_def_ff <= 1'b1;
      hs_ff <= {HVIO_N{1'b0}};
      ls_ff <= {HVIO_N{1'b0}};
      fs_ff <= {HVIO_N{1'b0}};
      can_ff <= `SBCMD_CAN_OFF;
      lin1_ff <= `SBCMD_LIN_OFF;
      lin2_ff <= `SBCMD_LIN_OFF;
      crx_ff <= 1'b1;
      lrx_ff <= 2'h3;
      en_o_ff <= 1'b0;
      en_oe_ff <= 1'b0;
      rst_low_ff <= 1'b0;
      fb_oe_ff <= 1'b0;
      spi_ff <= `SBCMD_SPI_DIS;
      wd_ff <= `SBCMD_WD_OFF;
    end else begin
      v2_ff <= nxt_v2;
      smps_ff <= nxt_smps;
      smps_def_ff <= nxt_smps_def;
      hs_ff <= nxt_hs;
      ls_ff <= nxt_ls;
      fs_ff <= nxt_fs;
      can_ff <= nxt_can;
      lin1_ff <= nxt_lin1;
      lin2_ff <= nxt_lin2;
      crx_ff <= nxt_crx;
      lrx_ff <= nxt_lrx;
      en_o_ff <= nxt_en_o;
      en_oe_ff <= nxt_en_oe;
      rst_low_ff <= nxt_rst_low;
      fb_oe_ff <= nxt_fb_oe;
      spi_ff <= nxt_spi;
      wd_ff <= nxt_wd;
    end
  end
  // Every output but fallback_o, tied low, comes straight from its flop
  assign prdata = prdata_ff, pready = pready_ff, pslverr = pslverr_ff;
  assign secondary_regulator = v2_ff, smps_on = smps_ff, smps_default_v = smps_def_ff;
  assign hv_io_hs_en = hs_ff, hv_io_ls_en = ls_ff, hv_io_failsafe = fs_ff;
  assign can_state = can_ff, lin1_state = lin1_ff, lin2_state = lin2_ff;
  assign can_receive_out = crx_ff, lin_receive_out = lrx_ff;
  assign en_pin_o = en_o_ff, en_pin_oe = en_oe_ff, reset_out_low = rst_low_ff;
  assign fallback_o = 1'b0, fallback_oe = fb_oe_ff; // Active fallback always pulls low
  assign spi_state = spi_ff, wd_mode = wd_ff;
endmodule // sbcmd_decoder

//--- hdl/sbcmd_defines.vh
// Purpose: constants for the operating-mode output decoder
// Assumes: included by every decoder file
// Notes: register offsets are byte addresses on APB
`ifndef SBCMD_DEFINES_VH
`define SBCMD_DEFINES_VH
// Chip operating mode codes
`define SBCMD_M_OFF 3'h0
`define SBCMD_M_FNM 3'h1
`define SBCMD_M_STB 3'h2
`define SBCMD_M_NRM 3'h3
`define SBCMD_M_SLP 3'h4
`define SBCMD_M_RST 3'h5
`define SBCMD_M_OVL 3'h6
`define SBCMD_M_FSP 3'h7
// Register byte offsets
`define SBCMD_OFS_CTRL 8'h00
`define SBCMD_OFS_FSAFE 8'h04
`define SBCMD_OFS_HVIO 8'h08
`define SBCMD_OFS_STAT 8'h0C
// Control register fields
`define SBCMD_CTRL_W 13
`define SBCMD_CTRL_RST 13'h0800
`define SBCMD_V2C_LSB 0
`define SBCMD_SMPS_ON 2
`define SBCMD_SMPS_ALT 3
`define SBCMD_CMC_LSB 4
`define SBCMD_LMC1_LSB 6
`define SBCMD_LMC2_LSB 8
`define SBCMD_WMC_LSB 10
// Fail-safe register fields
`define SBCMD_FSAFE_W 4
`define SBCMD_FSAFE_RST 4'h0
`define SBCMD_ENC_LSB 0
`define SBCMD_EN_PIN_DRIVE_CFG_BIT 2
`define SBCMD_LHC_BIT 3
// Transceiver mode field codes
`define SBCMD_MC_OFFL 2'h0
`define SBCMD_MC_ACT1 2'h1
`define SBCMD_MC_ACT2 2'h2
`define SBCMD_MC_LSN 2'h3
// CAN transceiver states
`define SBCMD_CAN_OFF 3'h0
`define SBCMD_CAN_OFFL 3'h1
`define SBCMD_CAN_BIAS 3'h2
`define SBCMD_CAN_LSN 3'h3
`define SBCMD_CAN_ACT 3'h4
// LIN transceiver states
`define SBCMD_LIN_OFF 2'h0
`define SBCMD_LIN_OFFL 2'h1
`define SBCMD_LIN_LSN 2'h2
`define SBCMD_LIN_ACT 2'h3
// Serial port states
`define SBCMD_SPI_DIS 2'h0
`define SBCMD_SPI_LIM 2'h1
`define SBCMD_SPI_ACT 2'h2
// Watchdog off code
`define SBCMD_WD_OFF 3'h0
`endif

//--- hdl/sbcmd_lin_dec.v
// Purpose: one LIN channel state and receive-line decode
// Assumes: mode and field inputs already registered
// Notes: purely combinational, registered by the parent
`timescale 1ns/10ps
`include "sbcmd_defines.vh"
module sbcmd_lin_dec (
  // Mode and control
  input wire [2:0] mode,
  input wire [1:0] lin_mode_ctrl,
  input wire present,
  // Bus side
  input wire wake,
  input wire bus_rx,
  // Decoded
  output reg [1:0] state,
  output reg lin_receive_out
);
  reg show;
  // Transceiver state and receive-line source per mode
  always @* begin
    state = `SBCMD_LIN_OFF;
    lin_receive_out = 1'b1;
    show = (lin_mode_ctrl == `SBCMD_MC_ACT1) || (lin_mode_ctrl == `SBCMD_MC_ACT2);
    case (mode)
      `SBCMD_M_FNM: begin
        state = `SBCMD_LIN_ACT;
        lin_receive_out = bus_rx;
      end
      `SBCMD_M_STB: begin
        // Active not allowed here, falls back to offline
        state = (lin_mode_ctrl == `SBCMD_MC_LSN) ? `SBCMD_LIN_LSN : `SBCMD_LIN_OFFL;
        lin_receive_out = (lin_mode_ctrl == `SBCMD_MC_LSN) ? bus_rx : ~wake;
      end
      `SBCMD_M_NRM: begin
        if (show) begin
          state = `SBCMD_LIN_ACT;
        end else if (lin_mode_ctrl == `SBCMD_MC_LSN) begin
          state = `SBCMD_LIN_LSN;
        end else begin
          state = `SBCMD_LIN_OFFL;
        end
        // Listen shows the bus here just as in Standby
        lin_receive_out = (lin_mode_ctrl != `SBCMD_MC_OFFL) ? bus_rx : ~wake;
      end
      `SBCMD_M_RST: begin
        state = `SBCMD_LIN_OFFL;
        lin_receive_out = ~wake;
      end
      `SBCMD_M_SLP, `SBCMD_M_FSP: begin
        state = `SBCMD_LIN_OFFL;
      end
      default: begin
        state = `SBCMD_LIN_OFF;
      end
    endcase
    // Absent channel stays off and pulled up
    if (!present) begin
      state = `SBCMD_LIN_OFF;
      lin_receive_out = 1'b1;
    end
  end
endmodule // sbcmd_lin_dec

//--- tb/sbcmd_decoder_chk.sv
// Purpose: concurrent checks on the mode-forced outputs of the decoder
// Assumes: every output shows the mode sampled one pclk earlier
// Notes: field-driven modes are left to the bench scoreboard
`timescale 1ns/10ps
`include "sbcmd_defines.vh"
module sbcmd_chk #(
  parameter HVIO_N = 8
) (
  // Clock, reset and conditions
  input wire pclk,
  input wire presetn,
  input wire [2:0] chip_mode,
  input wire can_shutdown,
  input wire pslverr,
  // Decoded outputs
  input wire secondary_regulator,
  input wire smps_on,
  input wire [HVIO_N-1:0] hv_io_ls_en,
  input wire [2:0] can_state,
  input wire [1:0] lin1_state,
  input wire en_pin_oe,
  input wire reset_out_low,
  input wire fallback_oe,
  input wire [1:0] spi_state,
  input wire [2:0] wd_mode
);
  reg [2:0] m_ff;
  reg sd_ff;
  reg live_ff;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Inputs of the last edge; live_ff hides the first edge, whose outputs still hold reset values
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ff <= 3'h0;
      sd_ff <= 1'b0;
      live_ff <= 1'b0;
    end else begin
      m_ff <= chip_mode;
      sd_ff <= can_shutdown;
      live_ff <= 1'b1;
    end
  end
  a_sec_reg_off: assert property (live_ff && m_ff inside {`SBCMD_M_OFF, `SBCMD_M_OVL}
    |-> !secondary_regulator) else $error("secondary regulator on while forced off");
  a_sec_reg_fnm: assert property (live_ff && m_ff == `SBCMD_M_FNM |-> secondary_regulator)
    else $error("secondary regulator off in forced normal");
  a_smps_forced: assert property (live_ff && m_ff inside {0, 1, 5, 6, 7}
    |-> smps_on == (m_ff inside {`SBCMD_M_FNM, `SBCMD_M_RST, `SBCMD_M_FSP}))
    else $error("smps state wrong in forced mode");
  a_hvio_ls_off: assert property (live_ff && !(m_ff inside {`SBCMD_M_NRM, `SBCMD_M_OVL})
    |-> hv_io_ls_en == '0) else $error("low-side driver on outside normal");
  a_can_forced_off: assert property (live_ff && (sd_ff || m_ff inside {0, 6})
    |-> can_state == `SBCMD_CAN_OFF) else $error("can not off when forced");
  a_lin_forced: assert property (live_ff && !(m_ff inside {`SBCMD_M_STB, `SBCMD_M_NRM})
    |-> lin1_state == (m_ff inside {0, 6} ? `SBCMD_LIN_OFF : m_ff == `SBCMD_M_FNM ?
    `SBCMD_LIN_ACT : `SBCMD_LIN_OFFL)) else $error("lin state wrong in forced mode");
  a_en_pin_off: assert property (live_ff && m_ff inside {0, 1} |-> !en_pin_oe)
    else $error("enable pin driven in off or forced normal");
  a_reset_level: assert property (live_ff
    |-> reset_out_low == (m_ff inside {`SBCMD_M_FNM, `SBCMD_M_STB, `SBCMD_M_NRM}))
    else $error("reset output level wrong for mode");
  a_fallback_mode: assert property (live_ff && m_ff inside {0, 1, 6, 7}
    |-> fallback_oe == (m_ff inside {6, 7})) else $error("fallback wrong in forced mode");
  a_fallback_sticky: assert property ((live_ff && m_ff == `SBCMD_M_OVL) ##1
    (m_ff == `SBCMD_M_STB) |-> fallback_oe) else $error("fallback bit lost after overload");
  a_spi_state: assert property (live_ff |-> spi_state == (m_ff inside {2, 3} ?
    `SBCMD_SPI_ACT : m_ff == `SBCMD_M_FNM ? `SBCMD_SPI_LIM : `SBCMD_SPI_DIS))
    else $error("serial port state wrong for mode");
  a_wd_off: assert property (live_ff && !(m_ff inside {2, 3, 4})
    |-> wd_mode == `SBCMD_WD_OFF) else $error("watchdog running in off mode");
  // Main scenarios reached
  cover property (live_ff && m_ff == `SBCMD_M_OVL && fallback_oe);
  cover property (live_ff && m_ff == `SBCMD_M_SLP && en_pin_oe);
  cover property (pslverr);
endmodule // sbcmd_chk
bind sbcmd_decoder sbcmd_chk #(.HVIO_N(HVIO_N)) sbcmd_chk_inst (
  .pclk(pclk), .presetn(presetn), .chip_mode(chip_mode), .can_shutdown(can_shutdown),
  .pslverr(pslverr), .secondary_regulator(secondary_regulator), .smps_on(smps_on),
  .hv_io_ls_en(hv_io_ls_en), .can_state(can_state), .lin1_state(lin1_state),
  .en_pin_oe(en_pin_oe), .reset_out_low(reset_out_low), .fallback_oe(fallback_oe),
  .spi_state(spi_state), .wd_mode(wd_mode)
);

//--- tb/sbcmd_decoder_test.sv
// Purpose: self-checking bench for the operating-mode output decoder
// Assumes: APB answers after one wait state, outputs lag inputs by one pclk
// Notes: 8-bit constants below are sets of modes indexed by mode code
`timescale 1ns/10ps
`include "sbcmd_defines.vh"
module sbcmd_decoder_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, hs, ls, fs;
  logic [31:0] pwdata, prdata;
  logic [2:0] chip_mode, can_state, wd_mode, rx_seen;
  logic can_shutdown, can_wake, can_bus_rx, sec, smps, en_oe, rst_n, fb_oe, can_rx, rx_valid;
  logic en_o, smps_d, fb_o;
  logic [1:0] lin_wake, lin_bus_rx, lin1_state, lin2_state, spi_state, lin_rx;
  integer n_errors = 0;
  integer n_tests = 0;
  wire [38:0] dec_v = {sec, smps, rst_n, spi_state, wd_mode, lin1_state, can_state, en_oe,
    fb_oe, ls, hs, fs};
  sbcmd_decoder sbcmd_decoder_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_mode(chip_mode), .can_shutdown(can_shutdown), .can_wake(can_wake),
    .lin_wake(lin_wake), .can_bus_rx(can_bus_rx), .lin_bus_rx(lin_bus_rx),
    .secondary_regulator(sec), .smps_on(smps), .smps_default_v(smps_d), .hv_io_hs_en(hs),
    .hv_io_ls_en(ls), .hv_io_failsafe(fs), .can_state(can_state), .lin1_state(lin1_state),
    .lin2_state(lin2_state), .can_receive_out(can_rx), .lin_receive_out(lin_rx), .en_pin_o(en_o),
    .en_pin_oe(en_oe), .reset_out_low(rst_n), .fallback_o(fb_o), .fallback_oe(fb_oe),
    .spi_state(spi_state), .wd_mode(wd_mode)
  );
  sbcmd_host_model sbcmd_host_model_inst (
    .pclk(pclk), .reset_out_low(rst_n), .can_receive_out(can_rx),
    .lin_receive_out(lin_rx), .rx_seen_ff(rx_seen), .rx_valid_ff(rx_valid)
  );
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; data compared only on reads without error
  task apb(input [7:0] a, input w, input [31:0] d, input [31:0] x, input e);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
        @(posedge pclk);
        k = k + 1;
      end
      if (k == 20) n_errors = n_errors + 1;
      chk({pslverr, (w | e) ? 32'h0 : prdata}, {e, (w | e) ? 32'h0 : x});
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  function is_in(input [2:0] m, input [7:0] s);
    is_in = s[m];
  endfunction
  // Expected decode of one mode under given control and fail-safe fields
  function [38:0] expv(input [2:0] m, input [12:0] c, input [3:0] f);
    reg nrm, fol, en, fb;
    reg [1:0] lin, spi;
    reg [2:0] can;
    begin
      nrm = (m == `SBCMD_M_NRM);
      fol = is_in(m, 8'h1C);
      if (is_in(m, 8'h41)) lin = `SBCMD_LIN_OFF;
      else if (m == `SBCMD_M_FNM) lin = `SBCMD_LIN_ACT;
      else if (!is_in(m, 8'h0C) || c[7:6] == 2'h0) lin = `SBCMD_LIN_OFFL;
      else if (c[7:6] == 2'h3) lin = `SBCMD_LIN_LSN;
      else lin = nrm ? `SBCMD_LIN_ACT : `SBCMD_LIN_OFFL;
      if (is_in(m, 8'h41)) can = `SBCMD_CAN_OFF;
      else if (m == `SBCMD_M_FNM) can = `SBCMD_CAN_ACT;
      else if (c[5:4] == 2'h0) can = `SBCMD_CAN_OFFL;
      else if (c[5:4] == 2'h3 && fol) can = `SBCMD_CAN_LSN;
      else can = nrm ? `SBCMD_CAN_ACT : `SBCMD_CAN_BIAS;
      spi = is_in(m, 8'h0C) ? `SBCMD_SPI_ACT : (m == `SBCMD_M_FNM) ? `SBCMD_SPI_LIM : 2'h0;
      if (is_in(m, 8'h63)) en = 1'b0;
      else en = (m == `SBCMD_M_SLP || f[2]) ? ~f[0] : f[1];
      fb = is_in(m, 8'hC0) | (f[3] & ~is_in(m, 8'h03));
      expv = {m == `SBCMD_M_FNM || (!is_in(m, 8'h41) && c[1:0] != 2'h0),
        is_in(m, 8'hA2) || (fol && c[2]), is_in(m, 8'h0E), spi, fol ? c[12:10] : 3'h0,
        lin, can, en, fb, {8{nrm}}, {8{is_in(m, 8'hBC)}}, {8{m == `SBCMD_M_OVL}}};
    end
  endfunction
  // Reset values, read-back width, refused accesses
  task t_regs;
    begin
      apb(`SBCMD_OFS_CTRL, 1'b0, 32'h0, {19'h0, `SBCMD_CTRL_RST}, 1'b0);
      apb(`SBCMD_OFS_FSAFE, 1'b0, 32'h0, 32'h0, 1'b0);
      apb(`SBCMD_OFS_HVIO, 1'b0, 32'h0, 32'h0, 1'b0);
      apb(8'h10, 1'b0, 32'h0, 32'h0, 1'b1);
      apb(`SBCMD_OFS_STAT, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b1);
      apb(`SBCMD_OFS_CTRL, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b0);
      apb(`SBCMD_OFS_CTRL, 1'b0, 32'h0, 32'h00001FFF, 1'b0);
    end
  endtask
  // Program fields in Standby, then walk all eight modes
  task t_sweep(input [12:0] c, input [3:0] f);
    integer i;
    reg [38:0] e;
    begin
      chip_mode <= `SBCMD_M_STB;
      apb(`SBCMD_OFS_CTRL, 1'b1, {19'h0, c}, 32'h0, 1'b0);
      apb(`SBCMD_OFS_FSAFE, 1'b1, {28'h0, f}, 32'h0, 1'b0);
      apb(`SBCMD_OFS_HVIO, 1'b1, 32'h0000FFFF, 32'h0, 1'b0);
      for (i = 0; i < 8; i = i + 1) begin
        chip_mode <= i[2:0];
        repeat (2) @(posedge pclk);
        e = expv(i[2:0], c, f);
        chk(dec_v[38:29], e[38:29]);
        chk(dec_v[28:0], e[28:0]);
        chk({fb_o, en_o, smps_d, lin2_state},
          {1'b0, !is_in(i[2:0], 8'h73) && !f[2] && f[0], i == 1 || !c[3],
          is_in(i[2:0], 8'h41) ? `SBCMD_LIN_OFF : i == 1 ? `SBCMD_LIN_ACT : `SBCMD_LIN_OFFL});
      end
    end
  endtask
  // Overload sets the fallback bit, software may clear it only afterwards
  task t_fallback;
    begin
      chip_mode <= `SBCMD_M_STB;
      apb(`SBCMD_OFS_FSAFE, 1'b1, 32'h0, 32'h0, 1'b0);
      chip_mode <= `SBCMD_M_OVL;
      apb(`SBCMD_OFS_FSAFE, 1'b1, 32'h0, 32'h0, 1'b0);
      apb(`SBCMD_OFS_FSAFE, 1'b0, 32'h0, 32'h8, 1'b0);
      chip_mode <= `SBCMD_M_STB;
      repeat (2) @(posedge pclk);
      chk(fb_oe, 1'b1);
      apb(`SBCMD_OFS_FSAFE, 1'b1, 32'h0, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      chk(fb_oe, 1'b0);
    end
  endtask
  // Receive lines on wake and listen, plus CAN shutdown
  task t_rx;
    begin
      chip_mode <= `SBCMD_M_STB;
      apb(`SBCMD_OFS_CTRL, 1'b1, 32'h0800, 32'h0, 1'b0);
      can_wake <= 1'b1;
      lin_wake <= 2'b01;
      repeat (3) @(posedge pclk);
      chk({rx_valid, rx_seen}, 4'b1100);
      chip_mode <= `SBCMD_M_SLP;
      repeat (3) @(posedge pclk);
      chk({rx_valid, rx_seen}, 4'b0111);
      chip_mode <= `SBCMD_M_RST;
      repeat (3) @(posedge pclk);
      chk({rx_valid, rx_seen}, 4'b0100);
      chip_mode <= `SBCMD_M_STB;
      can_wake <= 1'b0;
      lin_wake <= 2'b00;
      can_bus_rx <= 1'b0;
      lin_bus_rx <= 2'b00;
      apb(`SBCMD_OFS_CTRL, 1'b1, 32'h08F0, 32'h0, 1'b0);
      repeat (3) @(posedge pclk);
      chk({rx_valid, rx_seen}, 4'b1100);
      chip_mode <= `SBCMD_M_NRM;
      can_shutdown <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(can_state, `SBCMD_CAN_OFF);
      can_shutdown <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(can_state, `SBCMD_CAN_LSN);
      chk({rx_valid, rx_seen}, 4'b1100);
      apb(`SBCMD_OFS_STAT, 1'b0, 32'h0, 32'h0000A99B, 1'b0);
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chip_mode = `SBCMD_M_OFF;
    can_shutdown = 1'b0;
    can_wake = 1'b0;
    lin_wake = 2'b00;
    can_bus_rx = 1'b1;
    lin_bus_rx = 2'b11;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_sweep(13'h08F0, 4'h0);
    t_sweep(13'h0495, 4'h3);
    t_sweep(13'h006B, 4'hC);
    t_sweep(13'h0000, 4'h4);
    t_fallback;
    t_rx;
    print_verdict;
  end
  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    n_errors = n_errors + 1;
    print_verdict;
  end
endmodule // sbcmd_decoder_test

//--- tb/sbcmd_host_model.sv
// Purpose: host-side sampler of the receive and reset pins
// Assumes: host runs from the primary regulator
// Notes: pins count only while the host is out of reset
`timescale 1ns/10ps
module sbcmd_host_model (
  // Pins from the device
  input wire pclk,
  input wire reset_out_low,
  input wire can_receive_out,
  input wire [1:0] lin_receive_out,
  // Sampled view
  output reg [2:0] rx_seen_ff,
  output reg rx_valid_ff
);
  // Supply may be gone while reset is held, so lines are then untrusted
  always @(posedge pclk) begin
    rx_seen_ff <= {lin_receive_out, can_receive_out};
    rx_valid_ff <= reset_out_low;
  end
endmodule // sbcmd_host_model
